// file: shared/uart_pins_cfg.svh
// constants for the modem pin and interrupt block
// assumes an 8-bit register port and a 25 MHz reference clock
`ifndef UART_PINS_CFG_SVH
`define UART_PINS_CFG_SVH

// ==========================================
// register offsets
`define OFS_MODEM_CTRL 3'h0
`define OFS_MODEM_STAT 3'h1
`define OFS_INT_STAT 3'h2
`define OFS_INT_MASK 3'h3
`define OFS_RX_TICKS 3'h4

// ==========================================
// modem control fields
`define MCTL_DTR 0
`define MCTL_RTS 1
`define MCTL_USER_A 2
`define MCTL_USER_B 3
`define MCTL_LOOP 4

// ==========================================
// modem status fields
`define MSR_DSR_DELTA 1
`define MSR_DSR_LEVEL 5

// ==========================================
// interrupt status and mask fields
`define INT_RX_ERROR 0
`define INT_RX_DATA 1
`define INT_THR_EMPTY 2
`define INT_MODEM 3

// ==========================================
// reset values
`define RST_MODEM_CTRL 8'h00
`define RST_INT_STAT 8'h00
`define RST_INT_MASK 8'h00
// idle pins: unselected, low strobe high, no reset, DSR off, rclk low
`define RST_PINS 8'h32

// ==========================================
// timing
`define RCLK_DIV 16

`endif

// file: shared/uart_pins_pkg.sv
// types shared by the modem pin and interrupt block
// assumes nothing beyond the constants header
`default_nettype none

package uart_pins_pkg;

    // ==========================================
    // pin groups
    typedef struct packed {
        logic chip_select_a;
        logic chip_select_b;
        logic chip_select_c_low;
        logic read_strobe_low;
        logic read_strobe_high;
    } select_pins_type;

    typedef struct packed {
        logic rx_error;
        logic rx_data;
        logic rx_timeout;
        logic fifo_mode;
        logic thr_empty;
    } int_sources_type;

endpackage : uart_pins_pkg

`default_nettype wire

// file: verilog/pin_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes the pins are quasi-static against ref_clk
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] pins_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // ==========================================
    // stage one is read only by stage two
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    assign pins_sync = sync_q;

endmodule : pin_sync

`default_nettype wire

// file: verilog/rclk_divider.sv
// divides the synchronised receiver clock into one tick per bit time
// assumes rclk arrives already synchronised and well below ref_clk / 2
`default_nettype none
`include "uart_pins_cfg.svh"

module rclk_divider #(
    parameter int DIV = `RCLK_DIV
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic rclk_sync,
    output logic bit_tick,
    output logic [7:0] tick_count
);

    logic prev_q, prev_d;
    logic [4:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    logic [7:0] total_q, total_d;
    logic rise;

    // ==========================================
    // edge count
    always_comb begin
        rise = rclk_sync & ~prev_q;
        prev_d = rclk_sync;
        cnt_d = cnt_q;
        tick_d = 1'b0;
        total_d = total_q;
        if (rise) begin
            if (cnt_q == 5'(DIV - 1)) begin
                cnt_d = 5'h00;
                tick_d = 1'b1;
                total_d = total_q + 8'h01;
            end else begin
                cnt_d = cnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev_q <= 1'b0;
            cnt_q <= 5'h00;
            tick_q <= 1'b0;
            total_q <= 8'h00;
        end else begin
            prev_q <= prev_d;
            cnt_q <= cnt_d;
            tick_q <= tick_d;
            total_q <= total_d;
        end
    end

    assign bit_tick = tick_q;
    assign tick_count = total_q;

endmodule : rclk_divider

`default_nettype wire

// file: verilog/uart_modem_pin_interface.sv
// modem pins, read strobes, transceiver disable and interrupt of the serial element
// assumes a plain register port on ref_clk and asynchronous pins from the board
// Functional notes
// - transceiver_disable high whenever no read is in progress
// - modem status bit 5 shows the current data-set-ready level
// - modem status bit 1 flags a DSR change since the last status read
// - enabled modem status interrupt fires on a DSR change
// - DTR pin active low while its control bit is set
// - DTR inactive on master reset, in loop mode, or bit cleared
// - interrupt_out high while any unmasked interrupt is pending
// - four sources: rx error, rx data or timeout in fifo mode, thr empty, modem status
// - interrupt drops once serviced or on master reset
// - master reset clears control, mask and status bits and forces DTR, user outputs and interrupt to reset levels
// - user outputs active low while their control bits are set
// - user outputs high on master reset, loop mode, or bit 2/3 cleared
// - receiver timing comes from rclk at sixteen times the baud rate
// - selected and either read strobe active performs a register read
`default_nettype none
`include "uart_pins_cfg.svh"

module uart_modem_pin_interface
    import uart_pins_pkg::*;
#(
    parameter int ADDR_W = 3,
    parameter int DATA_W = 8,
    parameter int RX_DIV = `RCLK_DIV
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    input wire select_pins_type select_pins,
    input wire logic master_reset,
    input wire logic dsr_n,
    input wire logic rclk,
    input wire int_sources_type int_sources,
    output logic transceiver_disable,
    output logic interrupt_out,
    output logic dtr_n,
    output logic user_output_a_n,
    output logic user_output_b_n,
    output logic rx_bit_tick
);

    // ==========================================
    // pin synchronisation
    logic [7:0] pins_raw;
    logic [7:0] pins_s;
    logic mreset_s;
    logic dsr_pin_s;
    logic rclk_s;
    select_pins_type sel_s;

    assign pins_raw = {select_pins, master_reset, dsr_n, rclk};

    pin_sync #(
        .WIDTH(8),
        .INIT(`RST_PINS)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pins(pins_raw),
        .pins_sync(pins_s)
    );

    assign sel_s = select_pins_type'(pins_s[7:3]);
    assign mreset_s = pins_s[2];
    assign dsr_pin_s = pins_s[1];
    assign rclk_s = pins_s[0];

    // ==========================================
    // receiver clock
    logic [7:0] rx_ticks;

    rclk_divider #(
        .DIV(RX_DIV)
    ) u_rclk (
        .ref_clk(ref_clk),
        .rst(rst),
        .rclk_sync(rclk_s),
        .bit_tick(rx_bit_tick),
        .tick_count(rx_ticks)
    );

    // ==========================================
    // read qualification
    function automatic logic selected(input select_pins_type p);
        // all three selects must be active
        selected = p.chip_select_a & p.chip_select_b & ~p.chip_select_c_low;
    endfunction : selected

    logic pin_read;
    logic pin_read_prev_q;
    logic pin_read_rise;
    logic rd_take;
    logic wr_take;
    logic msr_read;

    // either strobe while selected; the unused one is assumed tied
    assign pin_read = selected(sel_s) & (~sel_s.read_strobe_low | sel_s.read_strobe_high);
    assign pin_read_rise = pin_read & ~pin_read_prev_q;
    assign rd_take = rd_en | pin_read_rise;
    assign wr_take = wr_en & ~rd_en;
    assign msr_read = rd_take && addr == `OFS_MODEM_STAT;

    assign transceiver_disable = ~(rd_en | pin_read);

    // ==========================================
    // control and interrupt registers
    logic [7:0] mctl_q, mctl_d;
    logic [7:0] ist_q, ist_d;
    logic [7:0] imask_q, imask_d;
    logic dsr_prev_q, dsr_prev_d;
    logic dsr_delta_q, dsr_delta_d;
    logic loop_mode;
    logic dsr_level;
    logic dsr_change;
    logic [7:0] ist_set;
    logic [7:0] msr_view;

    assign loop_mode = mctl_q[`MCTL_LOOP];
    // loop mode feeds DTR back in place of the pin; level shown as asserted-high
    assign dsr_level = loop_mode ? mctl_q[`MCTL_DTR] : ~dsr_pin_s;
    assign dsr_change = dsr_level != dsr_prev_q;

    always_comb begin
        msr_view = 8'h00;
        msr_view[`MSR_DSR_LEVEL] = dsr_level;
        msr_view[`MSR_DSR_DELTA] = dsr_delta_q;
    end

    always_comb begin
        ist_set = 8'h00;
        ist_set[`INT_RX_ERROR] = int_sources.rx_error;
        ist_set[`INT_RX_DATA] = int_sources.rx_data | (int_sources.rx_timeout & int_sources.fifo_mode);
        ist_set[`INT_THR_EMPTY] = int_sources.thr_empty;
        ist_set[`INT_MODEM] = dsr_change;
    end

    always_comb begin
        mctl_d = mctl_q;
        imask_d = imask_q;
        ist_d = ist_q;
        dsr_prev_d = dsr_level;
        dsr_delta_d = dsr_delta_q;
        if (wr_take && addr == `OFS_MODEM_CTRL) begin
            mctl_d = {3'h0, wdata[4:0]};
        end else if (wr_take && addr == `OFS_INT_MASK) begin
            imask_d = {4'h0, wdata[3:0]};
        end else if (wr_take && addr == `OFS_INT_STAT) begin
            ist_d = ist_q & ~wdata;
        end
        // status read clears the change flag and services the modem event
        if (msr_read) begin
            dsr_delta_d = 1'b0;
            ist_d[`INT_MODEM] = 1'b0;
        end
        if (dsr_change) begin
            dsr_delta_d = 1'b1;
        end
        ist_d = ist_d | ist_set;
        // master reset clears the register set
        if (mreset_s) begin
            mctl_d = `RST_MODEM_CTRL;
            imask_d = `RST_INT_MASK;
            ist_d = `RST_INT_STAT;
            dsr_delta_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mctl_q <= `RST_MODEM_CTRL;
            imask_q <= `RST_INT_MASK;
            ist_q <= `RST_INT_STAT;
            dsr_prev_q <= 1'b0;
            dsr_delta_q <= 1'b0;
            pin_read_prev_q <= 1'b0;
        end else begin
            mctl_q <= mctl_d;
            imask_q <= imask_d;
            ist_q <= ist_d;
            dsr_prev_q <= dsr_prev_d;
            dsr_delta_q <= dsr_delta_d;
            pin_read_prev_q <= pin_read;
        end
    end

    // level interrupt from unmasked pending bits
    assign interrupt_out = |(ist_q & imask_q);

    // ==========================================
    // modem output pins
    logic dtr_n_q, dtr_n_d;
    logic user_a_n_q, user_a_n_d;
    logic user_b_n_q, user_b_n_d;
    logic outs_forced;

    // forced inactive by reset or loop mode
    assign outs_forced = mreset_s | loop_mode;

    always_comb begin
        // active low follows the control bit
        dtr_n_d = outs_forced | ~mctl_q[`MCTL_DTR];
        // user outputs follow bits 2 and 3; forced high likewise
        user_a_n_d = outs_forced | ~mctl_q[`MCTL_USER_A];
        user_b_n_d = outs_forced | ~mctl_q[`MCTL_USER_B];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dtr_n_q <= 1'b1;
            user_a_n_q <= 1'b1;
            user_b_n_q <= 1'b1;
        end else begin
            dtr_n_q <= dtr_n_d;
            user_a_n_q <= user_a_n_d;
            user_b_n_q <= user_b_n_d;
        end
    end

    assign dtr_n = dtr_n_q;
    assign user_output_a_n = user_a_n_q;
    assign user_output_b_n = user_b_n_q;

    // ==========================================
    // read data, one cycle after the strobe
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        // unmapped addresses read zero
        if (rd_take) begin
            if (addr == `OFS_MODEM_CTRL) begin
                rdata_d = mctl_q;
            end else if (addr == `OFS_MODEM_STAT) begin
                rdata_d = msr_view;
            end else if (addr == `OFS_INT_STAT) begin
                rdata_d = ist_q;
            end else if (addr == `OFS_INT_MASK) begin
                rdata_d = imask_q;
            end else if (addr == `OFS_RX_TICKS) begin
                rdata_d = rx_ticks;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

    // ==========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_disable_on_read: assert property (rd_en |-> !transceiver_disable)
        else $error("transceiver disable high during a read");
    a_dsr_level_read: assert property (msr_read |=> rdata[`MSR_DSR_LEVEL] == $past(dsr_level))
        else $error("status read shows wrong DSR level");
    a_dsr_change_flag: assert property (dsr_change && !mreset_s |=> dsr_delta_q)
        else $error("DSR change not flagged");
    a_modem_int: assert property (dsr_change && imask_q[`INT_MODEM] && !mreset_s && !wr_take |=> interrupt_out)
        else $error("modem interrupt missing");
    a_dtr_active: assert property (mctl_q[`MCTL_DTR] && !loop_mode && !mreset_s |=> !dtr_n)
        else $error("DTR not active");
    a_dtr_forced: assert property (mreset_s ##1 mreset_s |-> dtr_n && user_output_a_n && user_output_b_n)
        else $error("outputs not forced by master reset");
    // sticky: only a write, a status read or master reset may drop the line
    a_int_held: assert property (|(ist_q & imask_q) && !mreset_s && !wr_take && !msr_read |=> interrupt_out)
        else $error("pending interrupt not held");
    a_source_latch: assert property (int_sources.rx_error && !mreset_s |=> ist_q[`INT_RX_ERROR])
        else $error("rx error not latched");
    a_int_cleared: assert property (mreset_s |=> !interrupt_out && mctl_q == `RST_MODEM_CTRL)
        else $error("interrupt survives master reset");
    a_user_active: assert property (mctl_q[`MCTL_USER_B] && !loop_mode && !mreset_s |=> !user_output_b_n)
        else $error("user output b not active");
    a_ctrl_readback: assert property (rd_take && addr == `OFS_MODEM_CTRL |=> rdata == $past(mctl_q))
        else $error("control register read back wrong");
    a_loop_forced: assert property (loop_mode |=> user_output_a_n && user_output_b_n && dtr_n)
        else $error("outputs not forced in loop mode");
    a_read_clears: assert property (msr_read && !dsr_change ##1 !dsr_change |-> !dsr_delta_q)
        else $error("change flag not cleared by read");

    c_modem_irq: cover property (dsr_change && imask_q[`INT_MODEM] ##1 interrupt_out);
    c_pin_read: cover property (pin_read_rise ##1 rdata != 8'h00);
    c_loop_entry: cover property (!loop_mode ##1 loop_mode);

endmodule : uart_modem_pin_interface

`default_nettype wire

// file: tb/modem_model.sv
// modem side model: data set ready level and receiver clock bursts
// assumes ref_clk is the bench clock; rclk rests low between bursts
`default_nettype none

module modem_model (
    input wire logic ref_clk,
    input wire logic dsr_on,
    input wire logic rclk_start,
    output logic dsr_n,
    output logic rclk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] burst_q = 7'h00;

    // ==========================================
    // data set ready, active low on the wire
    assign dsr_n = ~dsr_on;

    // ==========================================
    // receiver clock bursts
    // eight rclk periods a burst, slow enough for the sampler
    always @(posedge ref_clk) begin
        if (rclk_start && burst_q == 7'h00) begin
            burst_q <= 7'h40;
        end else if (burst_q != 7'h00) begin
            burst_q <= burst_q - 7'h01;
        end
    end
    assign rclk = burst_q[2];
endmodule : modem_model

`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the modem pin and interrupt block
// assumes the block's own assertions ride along in the design files
`default_nettype none
`include "uart_pins_cfg.svh"

module tb
    import uart_pins_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RXD = 2;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rdata;
    // high read strobe held inactive throughout
    select_pins_type sel = 5'b00110;
    logic master_reset = 1'b0;
    logic dsr_n;
    logic rclk;
    int_sources_type src = 5'h00;
    logic transceiver_disable;
    logic interrupt_out;
    logic dtr_n;
    logic user_output_a_n;
    logic user_output_b_n;
    logic rx_bit_tick;
    logic dsr_on = 1'b0;
    logic rclk_start = 1'b0;
    logic [7:0] tick_seen = 8'h00;
    int n_fail = 0;
    int check_count = 0;

    // ==========================================
    // clock, block and far side
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (rx_bit_tick === 1'b1) begin
            tick_seen <= tick_seen + 8'h01;
        end
    end

    uart_modem_pin_interface #(.RX_DIV(RXD)) dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .select_pins(sel), .master_reset(master_reset),
        .dsr_n(dsr_n), .rclk(rclk), .int_sources(src), .transceiver_disable(transceiver_disable),
        .interrupt_out(interrupt_out), .dtr_n(dtr_n), .user_output_a_n(user_output_a_n),
        .user_output_b_n(user_output_b_n), .rx_bit_tick(rx_bit_tick));

    modem_model partner (.ref_clk(ref_clk), .dsr_on(dsr_on), .rclk_start(rclk_start), .dsr_n(dsr_n),
        .rclk(rclk));

    // ==========================================
    // shared tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // bounded wait; running out ends the run
    task automatic wait_lvl(input string what, ref logic s, input logic exp);
        int i;
        for (i = 0; i < 12; i++) begin
            @(posedge ref_clk);
            #1;
            if (s === exp) break;
        end
        chk(what, s, exp);
        if (i == 12) finish_test();
    endtask : wait_lvl

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= a;
        #1;
        chk("xcvr_disable", transceiver_disable, 8'h00);
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask : rd

    task automatic pulse_src(input int_sources_type v);
        @(posedge ref_clk);
        src <= v;
        @(posedge ref_clk);
        src <= 5'h00;
    endtask : pulse_src

    // ==========================================
    // scenarios
    task automatic t_mctl();
        logic [7:0] mv [5] = '{8'h0D, 8'h1D, 8'h04, 8'h08, 8'h00};
        logic [2:0] pv [5] = '{3'b000, 3'b111, 3'b101, 3'b110, 3'b111};
        for (int i = 0; i < 5; i++) begin
            wr(3'h0, mv[i]);
            @(posedge ref_clk);
            #1;
            chk("out_pins", {dtr_n, user_output_a_n, user_output_b_n}, pv[i]);
            rd(3'h0, mv[i]);
        end
    endtask : t_mctl

    task automatic t_dsr();
        // loop mode entry and exit left a DSR change pending; this read also clears it
        rd(3'h1, 8'h02);
        wr(3'h3, 8'h08);
        @(posedge ref_clk);
        dsr_on <= 1'b1;
        wait_lvl("int_dsr", interrupt_out, 1'b1);
        rd(3'h1, 8'h22);
        chk("int_serviced", interrupt_out, 8'h00);
        rd(3'h1, 8'h20);
        @(posedge ref_clk);
        dsr_on <= 1'b0;
        wait_lvl("int_dsr", interrupt_out, 1'b1);
        rd(3'h1, 8'h02);
        rd(3'h1, 8'h00);
        wr(3'h3, 8'h00);
    endtask : t_dsr

    task automatic t_sources();
        int_sources_type sv [4] = '{5'b10000, 5'b01000, 5'b00110, 5'b00001};
        logic [7:0] sb [4] = '{8'h01, 8'h02, 8'h02, 8'h04};
        wr(3'h3, 8'h0F);
        for (int i = 0; i < 4; i++) begin
            pulse_src(sv[i]);
            wait_lvl("int_src", interrupt_out, 1'b1);
            rd(3'h2, sb[i]);
            wr(3'h2, sb[i]);
            #1;
            chk("int_cleared", interrupt_out, 8'h00);
        end
        // timeout outside fifo mode raises nothing
        pulse_src(5'b00100);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("int_timeout", interrupt_out, 8'h00);
        rd(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        pulse_src(5'b00001);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("int_masked", interrupt_out, 8'h00);
        rd(3'h2, 8'h04);
        wr(3'h2, 8'h04);
        rd(3'h2, 8'h00);
    endtask : t_sources

    task automatic t_pin_read();
        wr(3'h0, 8'h0A);
        @(posedge ref_clk);
        sel <= 5'b11100;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("xcvr_unselected", transceiver_disable, 8'h01);
        @(posedge ref_clk);
        sel <= 5'b11000;
        wait_lvl("xcvr_pin_read", transceiver_disable, 1'b0);
        @(posedge ref_clk);
        #1;
        chk("pin_rdata", rdata, 8'h0A);
        @(posedge ref_clk);
        sel <= 5'b00110;
        wait_lvl("xcvr_idle", transceiver_disable, 1'b1);
    endtask : t_pin_read

    task automatic t_master_reset();
        wr(3'h0, 8'h0D);
        wr(3'h3, 8'h04);
        pulse_src(5'b00001);
        wait_lvl("int_pre_reset", interrupt_out, 1'b1);
        @(posedge ref_clk);
        master_reset <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("reset_pins", {dtr_n, user_output_a_n, user_output_b_n}, 8'h07);
        chk("reset_int", interrupt_out, 8'h00);
        @(posedge ref_clk);
        master_reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(3'h0, 8'h00);
        rd(3'h3, 8'h00);
        rd(3'h2, 8'h00);
    endtask : t_master_reset

    task automatic t_rclk();
        logic [7:0] base;
        rd(3'h4, 8'h00);
        base = tick_seen;
        @(posedge ref_clk);
        rclk_start <= 1'b1;
        @(posedge ref_clk);
        rclk_start <= 1'b0;
        repeat (72) @(posedge ref_clk);
        #1;
        chk("bit_ticks", tick_seen - base, 8'(8 / RXD));
        rd(3'h4, 8'(8 / RXD));
    endtask : t_rclk

    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk("rst_pins", {dtr_n, user_output_a_n, user_output_b_n}, 8'h07);
        chk("rst_int", interrupt_out, 8'h00);
        chk("rst_xcvr", transceiver_disable, 8'h01);
        t_mctl();
        t_dsr();
        t_sources();
        t_pin_read();
        t_master_reset();
        t_rclk();
        finish_test();
    end
endmodule : tb

`default_nettype wire
